// ==== hw/lfa_top.sv ====
// Top of the link frame assembler: frame sequencing and octet packing.
`timescale 1ns/1ps
// Contract
// - Frame goes transmission header, link header, information field, trailer.
// - Information octets are carried unchanged between header and trailer.
// - Every octet leaves least significant bit first.
// - Ordinary fields pack their LSB into the lowest free octet bit.
// - Check sequence packs its MSB into the lowest free octet bit.
// - Field bits overflowing an octet continue from the next octet's bit zero.
// - Fields pack strictly in their defined order, octet after octet.
// - Transmitted octets are numbered consecutively from zero.
// - Header is flag, C/R plus source, extension plus destination, control.
// - Trailer is 32-bit check sequence then closing flag of 126.
// - Opening and closing flags both use pattern 01111110.
module lfa_top (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic bit_en_in,
  input wire logic [7:0] th_len_in,
  input wire logic [7:0] th_data_in,
  input wire logic cmd_resp_in,
  input wire logic [6:0] src_addr_in,
  input wire logic ext_in,
  input wire logic [6:0] dst_addr_in,
  input wire logic [7:0] ctrl_in,
  input wire logic [lfa_pkg::LFA_FCS_BITS-1:0] fcs_in,
  input wire logic info_valid_in,
  input wire logic [7:0] info_data_in,
  input wire logic info_last_in,
  output logic info_ready_out,
  output logic th_ready_out,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] octet_num_out,
  output logic tx_bit_out,
  output logic tx_valid_out
);
  import lfa_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    lfa_phase_t phase;
    logic [7:0] cnt;
    logic [7:0] th_len;
    logic cr;
    logic [6:0] src;
    logic ext;
    logic [6:0] dst;
    logic [7:0] ctl;
    logic [31:0] fcs;
    logic info_end;
    logic load;
    logic [7:0] oct;
    logic [15:0] num;
    logic info_rdy;
    logic th_rdy;
    logic done;
    logic txv;
    logic txb;
  } lfa_state_t;

  lfa_state_t st_q;
  lfa_state_t st_d;
  logic ser_busy;
  logic ser_last;
  logic ser_bit;
  logic need;

  // An octet slot opens when no load is pending and the serialiser is idle or its last bit is leaving.
  assign need = !st_q.load && (!ser_busy || ser_last);

  lfa_serializer u_ser (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .load_in(st_q.load),
    .octet_in(st_q.oct),
    .bit_en_in(bit_en_in),
    .busy_out(ser_busy),
    .last_out(ser_last),
    .bit_out(ser_bit)
  );

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    st_d = st_q;
    st_d.load = 1'b0;
    st_d.info_rdy = 1'b0;
    st_d.th_rdy = 1'b0;
    st_d.done = 1'b0;
    st_d.txv = ser_busy && bit_en_in;
    st_d.txb = ser_bit;
    if (st_q.load) begin
      st_d.num = st_q.num + 16'h0001;
    end
    unique case (st_q.phase)
      LFA_IDLE: begin
        if (start_in) begin
          st_d.th_len = th_len_in;
          st_d.cr = cmd_resp_in;
          st_d.src = src_addr_in;
          st_d.ext = ext_in;
          st_d.dst = dst_addr_in;
          st_d.ctl = ctrl_in;
          st_d.fcs = fcs_in;
          st_d.cnt = 8'h00;
          st_d.num = LFA_OCT_RST;
          st_d.phase = (th_len_in == 8'h00) ? LFA_HDR : LFA_TH;
        end
      end
      LFA_TH: begin
        // Transmission header octets are supplied raw; content is not built here.
        if (need) begin
          st_d.oct = th_data_in;
          st_d.load = 1'b1;
          st_d.th_rdy = 1'b1;
          st_d.cnt = st_q.cnt + 8'h01;
          if (st_q.cnt + 8'h01 == st_q.th_len) begin
            st_d.cnt = 8'h00;
            st_d.phase = LFA_HDR;
          end
        end
      end
      LFA_HDR: begin
        if (need) begin
          st_d.load = 1'b1;
          st_d.cnt = st_q.cnt + 8'h01;
          unique case (st_q.cnt[1:0])
            2'h0: st_d.oct = LFA_FLAG;
            2'h1: st_d.oct = {st_q.src, st_q.cr};
            2'h2: st_d.oct = {st_q.dst, st_q.ext};
            2'h3: st_d.oct = lfa_pack_lsb(st_q.ctl);
          endcase
          if (st_q.cnt[1:0] == 2'h3) begin
            st_d.cnt = 8'h00;
            st_d.info_end = 1'b0;
            st_d.phase = LFA_INFO;
          end
        end
      end
      LFA_INFO: begin
        // Octet acceptance waits for a free slot, so the source may stall freely.
        if (need && info_valid_in && !st_q.info_rdy) begin
          st_d.oct = info_data_in;
          st_d.load = 1'b1;
          st_d.info_rdy = 1'b1;
          if (info_last_in) begin
            st_d.phase = LFA_FCS;
          end
        end
      end
      LFA_FCS: begin
        if (need) begin
          st_d.load = 1'b1;
          st_d.oct = lfa_rev8(st_q.fcs[31:24]);
          st_d.fcs = {st_q.fcs[23:0], 8'h00};
          st_d.cnt = st_q.cnt + 8'h01;
          if (st_q.cnt[1:0] == LFA_FCS_LAST) begin
            st_d.cnt = 8'h00;
            st_d.phase = LFA_CFLAG;
          end
        end
      end
      LFA_CFLAG: begin
        if (need && !st_q.info_end) begin
          st_d.oct = LFA_FLAG;
          st_d.load = 1'b1;
          st_d.info_end = 1'b1;
        end else if (st_q.info_end && !ser_busy && !st_q.load) begin
          st_d.done = 1'b1;
          st_d.phase = LFA_IDLE;
        end
      end
      default: st_d.phase = LFA_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign info_ready_out = st_q.info_rdy;
  assign th_ready_out = st_q.th_rdy;
  assign busy_out = (st_q.phase != LFA_IDLE);
  assign done_out = st_q.done;
  assign octet_num_out = st_q.num;
  assign tx_bit_out = st_q.txb;
  assign tx_valid_out = st_q.txv;

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence hdr_end_s;
    st_q.phase == LFA_HDR && need && st_q.cnt[1:0] == 2'h3;
  endsequence

  hdr_to_info_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    hdr_end_s |=> st_q.phase == LFA_INFO && st_q.oct == $past(st_q.ctl))
    else $error("header did not hand over to information field");
  info_copy_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    info_ready_out |-> st_q.load && st_q.oct == $past(info_data_in))
    else $error("information octet altered");
  open_flag_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q.phase == LFA_HDR && need && st_q.cnt == 8'h00) |=> st_q.oct == 8'h7e)
    else $error("opening flag wrong");
  src_pack_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q.phase == LFA_HDR && need && st_q.cnt == 8'h01) |=> st_q.oct[0] == st_q.cr)
    else $error("command bit not in octet bit zero");
  fcs_msb_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q.phase == LFA_FCS && need) |=> st_q.oct[0] == $past(st_q.fcs[31]))
    else $error("check value MSB not sent first");
  octet_count_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q.load && st_q.phase != LFA_IDLE) |=> st_q.num == $past(st_q.num) + 16'h0001)
    else $error("octet number not consecutive");
  close_flag_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st_q.phase == LFA_FCS && need && st_q.cnt[1:0] == 2'h3) |=> st_q.phase == LFA_CFLAG)
    else $error("trailer flag not after four check octets");
  done_idle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    done_out |-> st_q.phase == LFA_IDLE && !ser_busy)
    else $error("frame ended with bits pending");
endmodule

// ==== hw/lfa_pkg.sv ====
// Package of constants for the link frame assembler.
package lfa_pkg;
  // ******************************************************************
  // Frame layout
  // ******************************************************************
  localparam logic [7:0] LFA_FLAG = 8'h7e;
  localparam int LFA_FCS_BITS = 32;
  localparam logic [2:0] LFA_LAST_BIT = 3'h7;
  localparam logic [7:0] LFA_TH_LEN_MAX = 8'hff;
  localparam logic [1:0] LFA_FCS_LAST = 2'h3;
  localparam logic [15:0] LFA_OCT_RST = 16'h0000;

  typedef enum logic [2:0] {
    LFA_IDLE,
    LFA_TH,
    LFA_HDR,
    LFA_INFO,
    LFA_FCS,
    LFA_CFLAG
  } lfa_phase_t;

  // Packs an 8-bit field value v into an octet unchanged, LSB in bit zero.
  function automatic logic [7:0] lfa_pack_lsb(input logic [7:0] v);
    lfa_pack_lsb = v;
  endfunction

  // Bit-reverses an octet so that the check value leaves MSB first.
  function automatic logic [7:0] lfa_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    lfa_rev8 = r;
  endfunction
endpackage

// ==== hw/lfa_serializer.sv ====
// Octet serialiser that shifts each octet out least significant bit first.
`timescale 1ns/1ps
module lfa_serializer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire logic [7:0] octet_in,
  input wire logic bit_en_in,
  output logic busy_out,
  output logic last_out,
  output logic bit_out
);
  import lfa_pkg::*;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic busy;
  } lfa_ser_t;

  lfa_ser_t s_q;
  lfa_ser_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_in) begin
      s_d.sh = octet_in;
      s_d.cnt = 3'h0;
      s_d.busy = 1'b1;
    end else if (s_q.busy && bit_en_in) begin
      s_d.sh = {1'b0, s_q.sh[7:1]};
      s_d.cnt = s_q.cnt + 3'h1;
      if (s_q.cnt == LFA_LAST_BIT) begin
        s_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out = s_q.busy;
  assign bit_out = s_q.sh[0];
  assign last_out = s_q.busy && bit_en_in && (s_q.cnt == LFA_LAST_BIT);

  // ******************************************************************
  // Checks
  // ******************************************************************
  shift_lsb_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (s_q.busy && bit_en_in && s_q.cnt != LFA_LAST_BIT) |=> bit_out == $past(s_q.sh[1]))
    else $error("serial bit not next higher octet bit");
  load_bit0_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    load_in |=> (bit_out == $past(octet_in[0])) && s_q.cnt == 3'h0)
    else $error("first serial bit is not octet bit zero");
endmodule

// ==== verif/lfa_phy_model.sv ====
// Physical-layer receiver model: paces bit times and rebuilds octets.
`timescale 1ns/1ps
module lfa_phy_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic clear_in,
  input wire logic tx_bit_in,
  input wire logic tx_valid_in,
  output logic bit_en_out
);
  logic [7:0] shift_q;
  logic [2:0] cnt_q = 3'h0;
  logic [1:0] pace_q = 2'h0;
  logic en_q = 1'b0;
  logic [7:0] octs[$];
  assign bit_en_out = en_q;
  // A slow line grants one bit time in three, so the sender must wait on it.
  always @(negedge clk_in) begin
    pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
    en_q <= !slow_in || (pace_q == 2'h0);
  end
  always @(posedge clk_in) begin
    if (clear_in) begin
      cnt_q <= 3'h0;
      octs.delete();
    end else if (tx_valid_in) begin
      shift_q <= {tx_bit_in, shift_q[7:1]};
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        octs.push_back({tx_bit_in, shift_q[7:1]});
      end
    end
  end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the link frame assembler.
`timescale 1ns/1ps
module tb;
  import lfa_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic start_in = 1'b0, info_valid_in = 1'b0, info_last_in = 1'b0;
  logic cmd_resp_in = 1'b0, ext_in = 1'b0, slow = 1'b0, clear = 1'b1;
  logic [7:0] th_len_in = 8'h00, th_data_in = 8'h00, ctrl_in = 8'h00, info_data_in = 8'h00;
  logic [6:0] src_addr_in = 7'h00, dst_addr_in = 7'h00;
  logic [31:0] fcs_in = 32'h0;
  logic bit_en, info_ready_out, th_ready_out, busy_out, done_out, tx_bit_out, tx_valid_out;
  logic [15:0] octet_num_out;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int n_compared = 0;
  always #5 clk_in = ~clk_in;
  lfa_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(start_in),
    .bit_en_in(bit_en), .th_len_in(th_len_in), .th_data_in(th_data_in),
    .cmd_resp_in(cmd_resp_in), .src_addr_in(src_addr_in), .ext_in(ext_in),
    .dst_addr_in(dst_addr_in), .ctrl_in(ctrl_in), .fcs_in(fcs_in),
    .info_valid_in(info_valid_in), .info_data_in(info_data_in),
    .info_last_in(info_last_in), .info_ready_out(info_ready_out),
    .th_ready_out(th_ready_out), .busy_out(busy_out), .done_out(done_out),
    .octet_num_out(octet_num_out), .tx_bit_out(tx_bit_out), .tx_valid_out(tx_valid_out));
  lfa_phy_model phy (.clk_in(clk_in), .slow_in(slow), .clear_in(clear),
    .tx_bit_in(tx_bit_out), .tx_valid_in(tx_valid_out), .bit_en_out(bit_en));
  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] flip(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      flip[i] = v[7 - i];
    end
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A second start and a changed source address mid-frame must not disturb it.
  task automatic send_frame(input int nth, input int ninfo, input logic [7:0] base,
                            input bit poke);
    int t, k, w;
    t = 0;
    k = 0;
    @(negedge clk_in);
    clear = 1'b1;
    th_len_in = nth[7:0];
    exp_q.delete();
    for (int i = 0; i < nth; i++) begin
      exp_q.push_back(8'ha0 + i[7:0]);
    end
    exp_q.push_back(8'h7e);
    exp_q.push_back({src_addr_in, cmd_resp_in});
    exp_q.push_back({dst_addr_in, ext_in});
    exp_q.push_back(ctrl_in);
    for (int i = 0; i < ninfo; i++) begin
      exp_q.push_back(base + 8'h13 * i[7:0]);
    end
    for (int i = 3; i >= 0; i--) begin
      exp_q.push_back(flip(fcs_in[8 * i +: 8]));
    end
    exp_q.push_back(8'h7e);
    th_data_in = 8'ha0;
    info_valid_in = 1'b1;
    info_data_in = base;
    info_last_in = (ninfo == 1);
    @(negedge clk_in);
    clear = 1'b0;
    start_in = 1'b1;
    for (w = 0; w < 3000 && !done_out; w++) begin
      @(negedge clk_in);
      start_in = poke && (w == 40);
      if (poke && w == 40) begin
        src_addr_in = ~src_addr_in;
      end
      if (th_ready_out) begin
        t++;
        th_data_in = 8'ha0 + t[7:0];
      end
      if (info_ready_out) begin
        k++;
        info_valid_in = (k < ninfo);
        info_data_in = base + 8'h13 * k[7:0];
        info_last_in = (k == ninfo - 1);
      end
    end
    check(octet_num_out, 16'(exp_q.size()));
    check(16'(phy.octs.size()), 16'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < phy.octs.size(); i++) begin
      check({8'h00, phy.octs[i]}, {8'h00, exp_q[i]});
    end
    info_valid_in = 1'b0;
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic test_example();
    slow = 1'b0;
    cmd_resp_in = 1'b0;
    src_addr_in = 7'h07;
    ext_in = 1'b1;
    dst_addr_in = 7'h04;
    ctrl_in = 8'h13;
    fcs_in = 32'hcae5e9ea;
    send_frame(0, 3, 8'h40, 1'b0);
  endtask
  task automatic test_th_slow();
    slow = 1'b1;
    cmd_resp_in = 1'b1;
    src_addr_in = 7'h55;
    ext_in = 1'b0;
    dst_addr_in = 7'h2a;
    ctrl_in = 8'hc3;
    fcs_in = 32'h80000001;
    send_frame(2, 1, 8'hf1, 1'b1);
    repeat (30) @(negedge clk_in);
    check({15'h0, busy_out}, 16'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    test_example();
    test_th_slow();
    give_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule
